// *** src/tw_wave_ctrl.sv ***
// Purpose: Compare-output and waveform-mode control of a 16-bit timer with two channels
// Assumes: Port direction and data come from logic on sys_clk; capture pin is asynchronous
// Notes:   Counter advances every sys_clk while the clock select field is nonzero and the waveform mode is not reserved
//
// Design decisions made here: register access over APB and the register addresses.
`include "tw_defs.svh"
module tw_wave_ctrl (
    input  wire logic             sys_clk,       // 10 MHz clock
    input  wire logic             reset,         // Asynchronous reset, active high
    input  wire logic             psel,          // APB select
    input  wire logic             penable,       // APB access phase
    input  wire logic             pwrite,        // APB write
    input  wire logic [11:0]      paddr,         // APB byte address
    input  wire logic [31:0]      pwdata,        // APB write data
    output logic      [31:0]      prdata,        // APB read data
    output logic                  pready,        // APB ready
    output logic                  pslverr,       // APB error on unmapped address
    input  wire tw_pkg::tw_pins_t port_data,     // Normal port output values
    input  wire tw_pkg::tw_pins_t port_dir,      // Port direction bits, 1 is output
    input  wire logic             capture_input_pin, // Asynchronous capture pin
    output tw_pkg::tw_pins_t      pin_out,       // Pin output values
    output tw_pkg::tw_pins_t      pin_oe_n,      // Pin driver enables, low drives
    output logic                  irq            // Level interrupt
);
    import tw_pkg::*;

    // Decode of the four-bit mode into sequence, TOP and event points
    function automatic tw_mode_t decode_mode(input logic [3:0] m);
        tw_mode_t d;
        d = '{TW_KIND_NORMAL, TW_TOP_FIXED, `TW_TOP_MAX, TW_PT_IMM, TW_PT_MAX};
        case (m)
            4'h0: d = '{TW_KIND_NORMAL, TW_TOP_FIXED, `TW_TOP_MAX, TW_PT_IMM, TW_PT_MAX};
            4'h1: d = '{TW_KIND_PC, TW_TOP_FIXED, `TW_TOP_8BIT, TW_PT_TOP, TW_PT_BOTTOM};
            4'h2: d = '{TW_KIND_PC, TW_TOP_FIXED, `TW_TOP_9BIT, TW_PT_TOP, TW_PT_BOTTOM};
            4'h3: d = '{TW_KIND_PC, TW_TOP_FIXED, `TW_TOP_10BIT, TW_PT_TOP, TW_PT_BOTTOM};
            4'h4: d = '{TW_KIND_CTC, TW_TOP_CMPA, `TW_TOP_MAX, TW_PT_IMM, TW_PT_MAX};
            4'h5: d = '{TW_KIND_FAST, TW_TOP_FIXED, `TW_TOP_8BIT, TW_PT_TOP, TW_PT_TOP};
            4'h6: d = '{TW_KIND_FAST, TW_TOP_FIXED, `TW_TOP_9BIT, TW_PT_TOP, TW_PT_TOP};
            4'h7: d = '{TW_KIND_FAST, TW_TOP_FIXED, `TW_TOP_10BIT, TW_PT_TOP, TW_PT_TOP};
            4'h8: d = '{TW_KIND_PFC, TW_TOP_CAPT, `TW_TOP_MAX, TW_PT_BOTTOM, TW_PT_BOTTOM};
            4'h9: d = '{TW_KIND_PFC, TW_TOP_CMPA, `TW_TOP_MAX, TW_PT_BOTTOM, TW_PT_BOTTOM};
            4'hA: d = '{TW_KIND_PC, TW_TOP_CAPT, `TW_TOP_MAX, TW_PT_TOP, TW_PT_BOTTOM};
            4'hB: d = '{TW_KIND_PC, TW_TOP_CMPA, `TW_TOP_MAX, TW_PT_TOP, TW_PT_BOTTOM};
            4'hC: d = '{TW_KIND_CTC, TW_TOP_CAPT, `TW_TOP_MAX, TW_PT_IMM, TW_PT_MAX};
            4'hD: d = '{TW_KIND_RESV, TW_TOP_FIXED, `TW_TOP_MAX, TW_PT_IMM, TW_PT_MAX};
            4'hE: d = '{TW_KIND_FAST, TW_TOP_CAPT, `TW_TOP_MAX, TW_PT_TOP, TW_PT_TOP};
            default: d = '{TW_KIND_FAST, TW_TOP_CMPA, `TW_TOP_MAX, TW_PT_TOP, TW_PT_TOP};
        endcase
        return d;
    endfunction : decode_mode

    // Connection of a channel to its pins for a given mode and output-mode field
    function automatic logic chan_connected(input tw_kind_t k, input logic [1:0] om,
                                            input logic msb, input logic is_a);
        logic c;
        c = (om != 2'b00);
        if (k == TW_KIND_RESV) begin
            c = 1'b0;
        end else if ((k == TW_KIND_PC || k == TW_KIND_PFC || k == TW_KIND_FAST) && om == 2'b01) begin
            c = msb && is_a;
        end
        return c;
    endfunction : chan_connected

    // Next waveform value for one channel
    function automatic logic wave_next(input logic cur, input tw_kind_t k, input logic [1:0] om,
                                       input logic msb, input logic is_a, input logic match,
                                       input logic at_top, input logic down, input logic force_s,
                                       input logic cmp_is_top);
        logic w;
        w = cur;
        case (k)
            TW_KIND_NORMAL, TW_KIND_CTC: begin
                if (match || force_s) begin
                    case (om)
                        2'b01:   w = ~cur;
                        2'b10:   w = 1'b0;
                        2'b11:   w = 1'b1;
                        default: w = cur;
                    endcase
                end
            end
            TW_KIND_FAST: begin
                if (om == 2'b01) begin
                    w = (msb && is_a && match) ? ~cur : cur;
                end else if (om[1] && at_top) begin
                    w = ~om[0];
                end else if (om[1] && match && !cmp_is_top) begin
                    w = om[0];
                end
            end
            TW_KIND_PC, TW_KIND_PFC: begin
                if (om == 2'b01) begin
                    w = (msb && is_a && match) ? ~cur : cur;
                end else if (om[1] && match) begin
                    w = down ? ~om[0] : om[0];
                end
            end
            default: w = 1'b0;
        endcase
        return w;
    endfunction : wave_next

    logic [7:0]  ctrl_a_r;
    logic [7:0]  ctrl_b_r;
    logic [7:0]  pin_enable_reg_r;
    logic [15:0] cmp_a_buf_r, cmp_b_buf_r, compare_reg_a_r, compare_reg_b_r;
    logic [15:0] capture_reg_r, count_r;
    logic        down_r, chan_a_wave_r, chan_b_wave_r, cap_s1_r, cap_s2_r, cap_prev_r;
    logic [3:0]  status_r, mask_r, rd_status_r;
    logic [31:0] prdata_r;
    logic        pslverr_r, irq_r;
    logic [1:0]  chan_a_out_mode, chan_b_out_mode;
    logic [3:0]  wave_mode;
    logic        wave_mode_msb, running, tick, at_top, at_bottom, match_a, match_b;
    logic        setup, access, wr_acc, rd_acc, cap_event, ovf_event, upd_now, force_a, force_b;
    logic [15:0] top_val;
    tw_mode_t    md;
    logic [3:0]  events;
    logic        hit;
    logic [31:0] rd_word;

    // Field extraction; bits 3:2 of control A are never stored
    assign chan_a_out_mode = ctrl_a_r[7:6];
    assign chan_b_out_mode = ctrl_a_r[5:4];
    assign wave_mode       = {ctrl_b_r[4:3], ctrl_a_r[1:0]};
    assign wave_mode_msb   = wave_mode[3];
    assign md              = decode_mode(wave_mode);

    // Counter state and event points
    assign running   = (ctrl_b_r[2:0] != 3'b000) && (md.kind != TW_KIND_RESV);
    assign tick      = running;
    assign top_val   = (md.top_src == TW_TOP_CMPA) ? compare_reg_a_r :
                       (md.top_src == TW_TOP_CAPT) ? capture_reg_r : md.fixed_top;
    assign at_top    = (count_r == top_val);
    assign at_bottom = (count_r == `TW_RESET_WORD);
    assign match_a   = tick && (count_r == compare_reg_a_r);
    assign match_b   = tick && (count_r == compare_reg_b_r);
    assign upd_now   = (md.upd_pt == TW_PT_IMM) || (tick && ((md.upd_pt == TW_PT_TOP && at_top) ||
                       (md.upd_pt == TW_PT_BOTTOM && at_bottom)));
    assign ovf_event = tick && ((md.ovf_pt == TW_PT_MAX && count_r == `TW_TOP_MAX) ||
                       (md.ovf_pt == TW_PT_TOP && at_top) ||
                       (md.ovf_pt == TW_PT_BOTTOM && at_bottom && down_r));

    // APB phases
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign wr_acc = access && pwrite && !pslverr_r;
    assign rd_acc = access && !pwrite;
    assign force_a = wr_acc && paddr == `TW_ADDR_FORCE && pwdata[`TW_FORCE_A_BIT] &&
                     (md.kind == TW_KIND_NORMAL || md.kind == TW_KIND_CTC);
    assign force_b = wr_acc && paddr == `TW_ADDR_FORCE && pwdata[`TW_FORCE_B_BIT] &&
                     (md.kind == TW_KIND_NORMAL || md.kind == TW_KIND_CTC);

    // Read mux and address decode
    always_comb begin
        hit     = 1'b1;
        rd_word = 32'h0000_0000;
        if (paddr == `TW_ADDR_CTRL_A) begin
            rd_word = {24'h00_0000, ctrl_a_r};
        end else if (paddr == `TW_ADDR_CTRL_B) begin
            rd_word = {24'h00_0000, ctrl_b_r};
        end else if (paddr == `TW_ADDR_FORCE) begin
            rd_word = 32'h0000_0000;
        end else if (paddr == `TW_ADDR_PIN_EN) begin
            rd_word = {24'h00_0000, pin_enable_reg_r};
        end else if (paddr == `TW_ADDR_CMP_A) begin
            rd_word = {16'h0000, cmp_a_buf_r};
        end else if (paddr == `TW_ADDR_CMP_B) begin
            rd_word = {16'h0000, cmp_b_buf_r};
        end else if (paddr == `TW_ADDR_CAPTURE) begin
            rd_word = {16'h0000, capture_reg_r};
        end else if (paddr == `TW_ADDR_COUNT) begin
            rd_word = {16'h0000, count_r};
        end else if (paddr == `TW_ADDR_STATUS) begin
            rd_word = {28'h000_0000, status_r};
        end else if (paddr == `TW_ADDR_MASK) begin
            rd_word = {28'h000_0000, mask_r};
        end else begin
            hit = 1'b0;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prdata_r    <= 32'h0000_0000;
            pslverr_r   <= 1'b0;
            rd_status_r <= 4'h0;
        end else if (setup) begin
            prdata_r    <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr_r   <= !hit;
            rd_status_r <= (!pwrite && paddr == `TW_ADDR_STATUS) ? status_r : 4'h0;
        end
    end
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r && access;
    assign pready  = 1'b1;

    // Control registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_a_r         <= `TW_RESET_BYTE;
            ctrl_b_r         <= `TW_RESET_BYTE;
            pin_enable_reg_r <= `TW_RESET_BYTE;
            mask_r           <= 4'h0;
        end else if (wr_acc) begin
            if (paddr == `TW_ADDR_CTRL_A) begin
                ctrl_a_r <= pwdata[7:0] & `TW_CTRL_A_WMASK;
            end else if (paddr == `TW_ADDR_CTRL_B) begin
                ctrl_b_r <= pwdata[7:0] & `TW_CTRL_B_WMASK;
            end else if (paddr == `TW_ADDR_PIN_EN) begin
                pin_enable_reg_r <= pwdata[7:0];
            end else if (paddr == `TW_ADDR_MASK) begin
                mask_r <= pwdata[3:0];
            end
        end
    end

    // Compare buffers and active compare values
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmp_a_buf_r     <= `TW_RESET_WORD;
            cmp_b_buf_r     <= `TW_RESET_WORD;
            compare_reg_a_r <= `TW_RESET_WORD;
            compare_reg_b_r <= `TW_RESET_WORD;
        end else begin
            if (wr_acc && paddr == `TW_ADDR_CMP_A) begin
                cmp_a_buf_r <= pwdata[15:0];
            end
            if (wr_acc && paddr == `TW_ADDR_CMP_B) begin
                cmp_b_buf_r <= pwdata[15:0];
            end
            if (upd_now) begin
                compare_reg_a_r <= cmp_a_buf_r;
                compare_reg_b_r <= cmp_b_buf_r;
            end
        end
    end

    // Counter: single slope wraps at TOP, dual slope turns at TOP and BOTTOM
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_r <= `TW_RESET_WORD;
            down_r  <= 1'b0;
        end else if (wr_acc && paddr == `TW_ADDR_COUNT) begin
            count_r <= pwdata[15:0];
        end else if (tick) begin
            if (md.kind == TW_KIND_PC || md.kind == TW_KIND_PFC) begin
                if (!down_r && count_r >= top_val) begin
                    down_r  <= 1'b1;
                    count_r <= count_r - 16'h0001;
                end else if (down_r && at_bottom) begin
                    down_r  <= 1'b0;
                    count_r <= count_r + 16'h0001;
                end else begin
                    count_r <= down_r ? count_r - 16'h0001 : count_r + 16'h0001;
                end
            end else begin
                down_r  <= 1'b0;
                count_r <= at_top ? `TW_RESET_WORD : count_r + 16'h0001;
            end
        end
    end

    // Capture pin synchroniser and capture register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cap_s1_r      <= 1'b0;
            cap_s2_r      <= 1'b0;
            cap_prev_r    <= 1'b0;
            capture_reg_r <= `TW_RESET_WORD;
        end else begin
            cap_s1_r   <= capture_input_pin;
            cap_s2_r   <= cap_s1_r;
            cap_prev_r <= cap_s2_r;
            if (wr_acc && paddr == `TW_ADDR_CAPTURE) begin
                capture_reg_r <= pwdata[15:0];
            end else if (cap_event) begin
                capture_reg_r <= count_r;
            end
        end
    end
    assign cap_event = (md.top_src != TW_TOP_CAPT) &&
                       (ctrl_b_r[`TW_EDGE_BIT] ? (cap_s2_r && !cap_prev_r) : (!cap_s2_r && cap_prev_r));

    // Waveform registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            chan_a_wave_r <= 1'b0;
            chan_b_wave_r <= 1'b0;
        end else begin
            chan_a_wave_r <= wave_next(chan_a_wave_r, md.kind, chan_a_out_mode, wave_mode_msb, 1'b1,
                                       match_a, tick && at_top, down_r, force_a, compare_reg_a_r == top_val);
            chan_b_wave_r <= wave_next(chan_b_wave_r, md.kind, chan_b_out_mode, wave_mode_msb, 1'b0,
                                       match_b, tick && at_top, down_r, force_b, compare_reg_b_r == top_val);
        end
    end

    // Pin muxing: compare output replaces the port only where its pin enable is set
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_enable_reg_r[i] && chan_connected(md.kind, chan_a_out_mode, wave_mode_msb, 1'b1)) begin
                pin_out.a[i]  = chan_a_wave_r;
                pin_oe_n.a[i] = !(port_dir.a[i] && pin_enable_reg_r[i]);
            end else begin
                pin_out.a[i]  = port_data.a[i];
                pin_oe_n.a[i] = !port_dir.a[i];
            end
            if (pin_enable_reg_r[4+i] && chan_connected(md.kind, chan_b_out_mode, wave_mode_msb, 1'b0)) begin
                pin_out.b[i]  = chan_b_wave_r;
                pin_oe_n.b[i] = !(port_dir.b[i] && pin_enable_reg_r[4+i]);
            end else begin
                pin_out.b[i]  = port_data.b[i];
                pin_oe_n.b[i] = !port_dir.b[i];
            end
        end
    end

    // Sticky status, cleared by a read of the bits that were returned; new events win
    assign events = {cap_event, match_b, match_a, ovf_event};
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_r <= 4'h0;
            irq_r    <= 1'b0;
        end else begin
            status_r <= (rd_acc ? (status_r & ~rd_status_r) : status_r) | events;
            irq_r    <= |(status_r & mask_r);
        end
    end
    assign irq = irq_r;

    // Checks
    a_resv_holds_count: assert property (@(posedge sys_clk) disable iff (reset)
        (wave_mode == 4'hD && !(wr_acc && paddr == `TW_ADDR_COUNT)) |=> $stable(count_r))
        else $error("count moved in reserved mode");
    a_resv_pins_port: assert property (@(posedge sys_clk) disable iff (reset)
        (wave_mode == 4'hD) |-> (pin_out == port_data))
        else $error("compare output connected in reserved mode");
    a_normal_wrap: assert property (@(posedge sys_clk) disable iff (reset)
        (wave_mode == 4'h0 && tick && count_r == 16'hFFFF && !wr_acc) |=> (count_r == 16'h0000 && status_r[0]))
        else $error("normal mode did not wrap at max with overflow");
    a_pin_dis_port: assert property (@(posedge sys_clk) disable iff (reset)
        (!pin_enable_reg_r[0]) |-> (pin_out.a[0] == port_data.a[0] && pin_oe_n.a[0] == !port_dir.a[0]))
        else $error("disabled pin not under port control");
    a_driver_gate: assert property (@(posedge sys_clk) disable iff (reset)
        (!pin_oe_n.b[1] && ctrl_a_r[5:4] != 2'b00 && pin_enable_reg_r[5]) |-> port_dir.b[1])
        else $error("driver enabled without direction bit");
    a_ctc_set_match: assert property (@(posedge sys_clk) disable iff (reset)
        (md.kind == TW_KIND_CTC && chan_a_out_mode == 2'b11 && match_a) |=> chan_a_wave_r)
        else $error("set on match failed");
    a_fast_top_set: assert property (@(posedge sys_clk) disable iff (reset)
        (md.kind == TW_KIND_FAST && chan_b_out_mode == 2'b10 && tick && at_top) |=> chan_b_wave_r)
        else $error("fast mode did not set at top");
    a_toggle_match: assert property (@(posedge sys_clk) disable iff (reset)
        ((md.kind == TW_KIND_NORMAL || md.kind == TW_KIND_CTC) && chan_a_out_mode == 2'b01 && match_a && !force_a) |=>
        (chan_a_wave_r != $past(chan_a_wave_r)))
        else $error("toggle on match failed");
    a_dual_up_clear: assert property (@(posedge sys_clk) disable iff (reset)
        (md.kind == TW_KIND_PC && chan_a_out_mode == 2'b10 && match_a && !down_r) |=> !chan_a_wave_r)
        else $error("up-count match did not clear");
    a_force_readzero: assert property (@(posedge sys_clk) disable iff (reset)
        (setup && !pwrite && paddr == `TW_ADDR_FORCE) |=> (prdata == 32'h0000_0000))
        else $error("force register read nonzero");
    a_cap_top_blocks: assert property (@(posedge sys_clk) disable iff (reset)
        (md.top_src == TW_TOP_CAPT && !(wr_acc && paddr == `TW_ADDR_CAPTURE)) |=> $stable(capture_reg_r))
        else $error("capture happened while capture value is TOP");

endmodule : tw_wave_ctrl

// *** src/tw_defs.svh ***
// Purpose: Offsets, field positions, reset values and fixed counts for the waveform output block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Register contents sit in the low bits, upper bits read as zero
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

`define TW_ADDR_CTRL_A     12'h000
`define TW_ADDR_CTRL_B     12'h004
`define TW_ADDR_FORCE      12'h008
`define TW_ADDR_PIN_EN     12'h00C
`define TW_ADDR_CMP_A      12'h010
`define TW_ADDR_CMP_B      12'h014
`define TW_ADDR_CAPTURE    12'h018
`define TW_ADDR_COUNT      12'h01C
`define TW_ADDR_STATUS     12'h020
`define TW_ADDR_MASK       12'h024

`define TW_CTRL_A_WMASK    8'hF3
`define TW_CTRL_B_WMASK    8'h5F
`define TW_RESET_BYTE      8'h00
`define TW_RESET_WORD      16'h0000
`define TW_TOP_8BIT        16'h00FF
`define TW_TOP_9BIT        16'h01FF
`define TW_TOP_10BIT       16'h03FF
`define TW_TOP_MAX         16'hFFFF
`define TW_EDGE_BIT        6
`define TW_FORCE_A_BIT     7
`define TW_FORCE_B_BIT     6
`define TW_ST_OVF          0
`define TW_ST_MATCH_A      1
`define TW_ST_MATCH_B      2
`define TW_ST_CAPTURE      3

`endif

// *** src/tw_pkg.sv ***
// Purpose: Types shared by the waveform output block
// Assumes: Nothing beyond SystemVerilog packed types
// Notes:   Mode decode travels as one packed struct
package tw_pkg;

    typedef enum logic [2:0] {
        TW_KIND_NORMAL  = 3'b000,
        TW_KIND_CTC     = 3'b001,
        TW_KIND_PC      = 3'b010,
        TW_KIND_PFC     = 3'b011,
        TW_KIND_FAST    = 3'b100,
        TW_KIND_RESV    = 3'b101
    } tw_kind_t;

    typedef enum logic [1:0] {
        TW_PT_IMM    = 2'b00,
        TW_PT_TOP    = 2'b01,
        TW_PT_BOTTOM = 2'b10,
        TW_PT_MAX    = 2'b11
    } tw_point_t;

    typedef enum logic [1:0] {
        TW_TOP_FIXED = 2'b00,
        TW_TOP_CMPA  = 2'b01,
        TW_TOP_CAPT  = 2'b10
    } tw_topsrc_t;

    typedef struct packed {
        tw_kind_t    kind;
        tw_topsrc_t  top_src;
        logic [15:0] fixed_top;
        tw_point_t   upd_pt;
        tw_point_t   ovf_pt;
    } tw_mode_t;

    typedef struct packed {
        logic [3:0] a;
        logic [3:0] b;
    } tw_pins_t;

endpackage : tw_pkg

// *** sim/tw_pin_model.sv ***
// Purpose: Pad model for the eight compare-capable pins
// Assumes: Released pads are pulled up
// Notes:   A pad follows the block only while its enable is low
module tw_pin_model (
    input  wire tw_pkg::tw_pins_t pin_out,  // Values from the block
    input  wire tw_pkg::tw_pins_t pin_oe_n, // Enables, low drives
    output tw_pkg::tw_pins_t      pad       // Resolved levels
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driven value, or pull-up level when released
    assign pad = (pin_out & ~pin_oe_n) | pin_oe_n;
endmodule : tw_pin_model

// *** sim/tw_wave_ctrl_tb.sv ***
// Purpose: Self-checking bench for the waveform output block
// Assumes: Capture pin held low
// Notes:   Driver queues expected replies, a monitor checks them
`include "tw_defs.svh"
module tw_wave_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tw_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, capture_input_pin = 1'b0;
    logic pready, pslverr, irq, v;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'hD19D;
    logic [33:0] exp_q[$];
    tw_pins_t port_data = 8'h00, port_dir = 8'h00, pin_out, pin_oe_n, pad;
    int num_errors = 0, n_compared = 0;
    // Block and pads
    tw_wave_ctrl i_dut (
        .sys_clk           (sys_clk),
        .reset             (reset),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .port_data         (port_data),
        .port_dir          (port_dir),
        .capture_input_pin (capture_input_pin),
        .pin_out           (pin_out),
        .pin_oe_n          (pin_oe_n),
        .irq               (irq)
    );
    tw_pin_model i_pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pad(pad));
    // Clock
    always #50 sys_clk = ~sys_clk;
    // Compare and count
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        num_errors += int'(got !== exp);
        if (got !== exp) $display("mismatch at %0t: %h vs %h", $time, got, exp);
    endtask : chk
    // Counts and verdict
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // Pseudo-random step
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // One transfer; f is {irq, pslverr}, d the read data expected
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [1:0] f);
        exp_q.push_back({f, wr ? 32'h0 : d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    // Each completed access takes the oldest note
    always @(posedge sys_clk)
        if (psel && penable && pready) chk({irq, pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    // Watchdog
    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, `TW_ADDR_CTRL_A, 32'h0, 2'b00);
        apb(1'b1, `TW_ADDR_CTRL_A, 32'hFC, 2'b00);
        apb(1'b0, `TW_ADDR_CTRL_A, 32'hF0, 2'b00);
        apb(1'b1, `TW_ADDR_FORCE, 32'hC0, 2'b00);
        apb(1'b0, `TW_ADDR_FORCE, 32'h0, 2'b00);
        apb(1'b0, 12'h030, 32'h0, 2'b01);
        apb(1'b1, `TW_ADDR_CMP_A, 32'h2, 2'b00);
        apb(1'b1, `TW_ADDR_PIN_EN, 32'h1, 2'b00);
        apb(1'b1, `TW_ADDR_CTRL_B, 32'h9, 2'b00);
        for (int m = 1; m < 4; m++) begin
            lfsr = lfsr_next(lfsr);
            port_data <= lfsr[7:0];
            port_dir <= {3'h0, m != 3, lfsr[11:8]};
            apb(1'b1, `TW_ADDR_CTRL_A, 32'h30 | (m << 6), 2'b00);
            repeat (10) @(negedge sys_clk);
            v = pad.a[0];
            chk({33'h0, pin_oe_n.a[0]}, {33'h0, m == 3});
            chk({26'h0, pin_oe_n.b, pin_out.b}, {26'h0, ~port_dir.b, port_data.b});
            repeat (3) @(negedge sys_clk);
            chk({33'h0, pad.a[0]}, {33'h0, (m == 1) ? ~v : m == 3});
            chk({33'h0, pin_out.a[0]}, {33'h0, (m == 1) ? ~v : m == 3});
            @(posedge sys_clk);
        end
        apb(1'b1, `TW_ADDR_MASK, 32'h2, 2'b00);
        apb(1'b1, `TW_ADDR_CTRL_B, 32'h8, 2'b10);
        apb(1'b0, `TW_ADDR_STATUS, 32'h6, 2'b10);
        apb(1'b0, `TW_ADDR_STATUS, 32'h0, 2'b00);
        end_sim();
    end
endmodule : tw_wave_ctrl_tb
